// [chgg_pkg.sv]
// chgg_pkg: constants, register map and carrier types of the charge gauge.
// assumes a 100 MHz system clock and a front end on the same clock.
package chgg_pkg;

  // register offsets
  localparam logic [7:0] CHGG_OFF_TEMP_GAUGE   = 8'h02;
  localparam logic [7:0] CHGG_OFF_CHG_HIGH     = 8'h03;
  localparam logic [7:0] CHGG_OFF_PACK_ID      = 8'h04;
  localparam logic [7:0] CHGG_OFF_FULL_CAP     = 8'h05;
  localparam logic [7:0] CHGG_OFF_SEC_FLAGS    = 8'h06;
  localparam logic [7:0] CHGG_OFF_PULLDOWN     = 8'h07;
  localparam logic [7:0] CHGG_OFF_PULLUP       = 8'h08;
  localparam logic [7:0] CHGG_OFF_RCHG_COUNT   = 8'h09;
  localparam logic [7:0] CHGG_OFF_FILTER       = 8'h0a;
  localparam logic [7:0] CHGG_OFF_CHG_LOW      = 8'h17;
  localparam logic [7:0] CHGG_OFF_SOFT_RESET   = 8'h39;

  // field positions in the secondary flag register
  localparam int unsigned CHGG_BIT_FAST_CHG    = 7;
  localparam int unsigned CHGG_BIT_RATE_LSB    = 4;
  localparam int unsigned CHGG_BIT_OVERLOAD    = 0;

  // reset values and fixed figures
  localparam logic [7:0]  CHGG_SOFT_RESET_CODE = 8'h80;
  localparam logic [7:0]  CHGG_PROG_FULL_COUNT = 8'h40; // programmed full count
  localparam logic [7:0]  CHGG_FILTER_RESET    = 8'h00;
  localparam logic [7:0]  CHGG_RCHG_MAX        = 8'hff;
  localparam logic [7:0]  CHGG_RCHG_INACC      = 8'h40; // 64 charges
  localparam logic [15:0] CHGG_NEAR_FULL_NUM   = 16'h005e; // 94 of 100
  localparam logic [15:0] CHGG_NEAR_FULL_DEN   = 16'h0064;
  localparam logic [3:0]  CHGG_TEMP_MAX        = 4'hc;  // above 80 C
  localparam logic [3:0]  CHGG_TEMP_ZERO_C     = 4'h4;  // 0 C band
  localparam logic [3:0]  CHGG_TEMP_MINUS20    = 4'h2;  // -20 C band
  localparam logic [7:0]  CHGG_EFF_FAST        = 8'hf0; // charge step, fast
  localparam logic [7:0]  CHGG_EFF_TRICKLE     = 8'hc0; // charge step, trickle
  localparam logic [15:0] CHGG_DIS_STEP        = 16'h0100;
  localparam logic [15:0] CHGG_SELF_DIS_STEP   = 16'h0010;
  localparam int unsigned CHGG_FIFTH_PROGRAM_PIN_BIT       = 4;     // fifth program pin

  // display timing
  localparam int unsigned CHGG_CLK_NS          = 10;
  localparam int unsigned CHGG_MUX_PERIOD_NS   = 10_000_000;  // 100 Hz
  localparam int unsigned CHGG_MUX_CYCLES      = CHGG_MUX_PERIOD_NS / CHGG_CLK_NS;
  localparam int unsigned CHGG_BANK_ON_PCT     = 30;
  localparam int unsigned CHGG_BLINK_HALF_NS   = 125_000_000; // 4 Hz
  localparam int unsigned CHGG_BLINK_CYCLES    = CHGG_BLINK_HALF_NS / CHGG_CLK_NS;

  // register access request from the serial port logic
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chgg_req_t;

  // events and levels from the measurement front end
  typedef struct packed {
    logic       chg_cnt;      // one charge count
    logic       dis_cnt;      // one discharge count
    logic       sd_cnt;       // one self-discharge count
    logic       chg_detect;   // charge detected
    logic       valid_chg;    // valid charge action
    logic       rate_low;     // charge rate below 2 counts/s
    logic       below_150;    // sense voltage below -150 mV
    logic       below_250;    // sense voltage below -250 mV
    logic       empty1_trip;  // battery voltage below first threshold
    logic       emptyf_trip;  // battery voltage below final threshold
    logic       sd_over;      // self-discharge count reached 4096
    logic       activity;     // counting faster than -4 mV equivalent
  } chgg_evt_t;

  // primary flags shown to the system
  typedef struct packed {
    logic cap_inacc;
    logic valid_dis;
    logic bat_repl;
    logic empty1;
    logic emptyf;
  } chgg_flags_t;

  // whole state of the register bank
  typedef struct packed {
    logic        dlo_s1, dlo_s2, dhi_s1, dhi_s2;
    logic [5:0]  pd_s1, pd_s2, pu_s1, pu_s2;
    logic [15:0] avail_chg;
    logic [7:0]  pack_id, full_cap, filt, rchg_cnt, dis_meas, rdata;
    logic [3:0]  temp_code;
    logic        fast_chg, rate_bit, ovl, rchg_hold;
    chgg_flags_t flg;
    logic        sd_en, rvalid, soft_rst;
  } chgg_state_t;

  // state of the display driver
  typedef struct packed {
    logic [23:0] phase;
    logic [23:0] blink_cnt;
    logic        blink;
    logic [4:0]  seg;
  } chgg_led_state_t;

endpackage : chgg_pkg

// [chgg_led_mux.sv]
// chgg_led_mux: two-bank multiplexing of five segments and low-battery blink of the first segment.
// assumes seg_on_i and the enables come from logic on the same clock.
`timescale 1ns/1ps
module chgg_led_mux #(
  parameter int unsigned MUX_CYCLES   = chgg_pkg::CHGG_MUX_CYCLES,
  parameter int unsigned BLINK_CYCLES = chgg_pkg::CHGG_BLINK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       en_i,
  input  wire logic       blink_i,
  input  wire logic [4:0] seg_on_i,
  output logic      [4:0] seg_o
);
  import chgg_pkg::*;

  localparam logic [23:0] PER_LAST = 24'(MUX_CYCLES - 1);
  localparam logic [23:0] A_END    = 24'(MUX_CYCLES * CHGG_BANK_ON_PCT / 100);
  localparam logic [23:0] B_START  = 24'(MUX_CYCLES / 2);
  localparam logic [23:0] B_END    = 24'(MUX_CYCLES / 2 + MUX_CYCLES * CHGG_BANK_ON_PCT / 100);
  localparam logic [23:0] BL_LAST  = 24'(BLINK_CYCLES - 1);
  localparam logic [4:0]  BANK_A   = 5'h15; // segments 1, 3, 5
  localparam logic [4:0]  BANK_B   = 5'h0a; // segments 2, 4

  chgg_led_state_t s_q, s_d;
  logic            bank_a, bank_b;
  logic [4:0]      shown;

  // phase counter, blink toggle and bank gating
  always_comb begin
    s_d    = s_q;
    bank_a = s_q.phase < A_END;
    bank_b = (s_q.phase >= B_START) && (s_q.phase < B_END);
    s_d.phase = (s_q.phase == PER_LAST) ? 24'h0 : s_q.phase + 24'h1;
    if (s_q.blink_cnt == BL_LAST) begin
      s_d.blink_cnt = 24'h0;
      s_d.blink     = ~s_q.blink;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 24'h1;
    end
    shown = seg_on_i;
    if (blink_i) begin
      shown[0] = seg_on_i[0] & s_q.blink;
    end
    s_d.seg = en_i ? (shown & ((bank_a ? BANK_A : 5'h0) | (bank_b ? BANK_B : 5'h0)))
                   : 5'h0;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign seg_o = s_q.seg;

  property p_bank_excl;
    @(posedge clk_i) disable iff (!nrst_i)
      !((seg_o & BANK_A) != 5'h0 && (seg_o & BANK_B) != 5'h0);
  endproperty
  a_bank_excl: assert property (p_bank_excl) else $error("both banks lit");

  property p_disabled_dark;
    @(posedge clk_i) disable iff (!nrst_i) !en_i |=> seg_o == 5'h0;
  endproperty
  a_disabled_dark: assert property (p_disabled_dark) else $error("segments lit while off");

  c_bank_b: cover property (@(posedge clk_i) disable iff (!nrst_i) (seg_o & BANK_B) != 5'h0);

endmodule : chgg_led_mux

// [chgg_regs.sv]
// chgg_regs: register bank, charge bookkeeping and display control.
// assumes the serial port logic and the front end run on clk_i.
`timescale 1ns/1ps
module chgg_regs #(
  parameter int unsigned MUX_CYCLES   = chgg_pkg::CHGG_MUX_CYCLES,
  parameter int unsigned BLINK_CYCLES = chgg_pkg::CHGG_BLINK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire chgg_pkg::chgg_req_t   req_i,
  input  wire chgg_pkg::chgg_evt_t   evt_i,
  input  wire logic [3:0]            temp_code_i,
  input  wire logic                  display_control_pin_low_i,
  input  wire logic                  display_control_pin_high_i,
  input  wire logic [5:0]            pulldown_i,
  input  wire logic [5:0]            pullup_i,
  output logic      [7:0]            rdata_o,
  output logic                       rvalid_o,
  output chgg_pkg::chgg_flags_t      flags_o,
  output logic      [7:0]            filter_o,
  output logic                       fast_chg_o,
  output logic                       sd_enable_o,
  output logic      [4:0]            led_segment_outputs_o
);
  import chgg_pkg::*;

  // number of steps k in 1..steps with num*steps reaching k*den (ceil mode: above (k-1)*den), at most 15
  function automatic logic [3:0] chgg_steps(input logic [7:0] num, input logic [7:0] den,
                                            input logic [4:0] steps, input logic ceil_mode);
    logic [15:0] lhs;
    logic [15:0] thr;
    logic [3:0]  cnt;
    lhs = 16'({8'h0, num} * {11'h0, steps});
    cnt = 4'h0;
    for (int k = 1; k <= 15; k++) begin
      thr = 16'({8'h0, den} * 16'(ceil_mode ? k - 1 : k));
      if (5'(k) <= steps && (ceil_mode ? (lhs > thr) : (lhs >= thr)) && den != 8'h0) begin
        cnt = cnt + 4'h1;
      end
    end
    return cnt;
  endfunction : chgg_steps

  // write strobe for one register offset
  function automatic logic chgg_hit(input chgg_req_t r, input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction : chgg_hit

  // saturating add and subtract on the charge counter
  function automatic logic [15:0] chgg_sat(input logic [15:0] v, input logic [15:0] up,
                                           input logic [15:0] dn);
    logic [16:0] s;
    s = {1'b0, v} + {1'b0, up};
    if (s[16]) begin
      s = 17'h0ffff;
    end
    return (s[15:0] < dn) ? 16'h0 : s[15:0] - dn;
  endfunction : chgg_sat

  chgg_state_t s_q, s_d;
  chgg_state_t s_rst;
  logic [7:0]  adj_chg;
  logic [3:0]  gauge;
  logic [3:0]  seg_cnt;
  logic [4:0]  seg_on;
  logic        near_full;
  logic        learn_ok;
  logic        display_control_pin_en;
  logic [15:0] up_step;
  logic [15:0] dn_step;

  // reset image of the state, soft reset keeps pins, id and filter
  always_comb begin
    s_rst           = s_q;
    s_rst.avail_chg = 16'h0;
    s_rst.full_cap  = CHGG_PROG_FULL_COUNT;
    s_rst.rchg_cnt  = 8'h0;
    s_rst.rchg_hold = 1'b0;
    s_rst.dis_meas  = 8'h0;
    s_rst.flg       = '{cap_inacc: 1'b1, valid_dis: 1'b0, bat_repl: 1'b1,
                        empty1: 1'b0, emptyf: 1'b0};
    s_rst.fast_chg  = 1'b0;
    s_rst.rate_bit  = 1'b0;
    s_rst.ovl       = 1'b0;
    s_rst.rvalid    = 1'b0;
    s_rst.soft_rst  = 1'b0;
  end

  // derived values: near-full test, adjusted charge, gauge and segment count
  always_comb begin
    near_full = ({8'h0, s_q.avail_chg[15:8]} * CHGG_NEAR_FULL_DEN)
              > ({8'h0, s_q.full_cap} * CHGG_NEAR_FULL_NUM);
    if (s_q.temp_code >= CHGG_TEMP_ZERO_C) begin
      adj_chg = s_q.avail_chg[15:8];
    end else if (s_q.temp_code >= CHGG_TEMP_MINUS20) begin
      adj_chg = s_q.avail_chg[15:8] - {2'h0, s_q.avail_chg[15:10]};
    end else begin
      adj_chg = {1'b0, s_q.avail_chg[15:9]};
    end
    gauge   = chgg_steps(adj_chg, s_q.full_cap, 5'h10, 1'b0);
    seg_cnt = chgg_steps(adj_chg, s_q.full_cap, 5'h05, 1'b1);
    for (int i = 0; i < 5; i++) begin
      seg_on[i] = 4'(i) < seg_cnt;
    end
    // display enable from the synchronised control pin
    if (s_q.dhi_s2 || s_q.flg.emptyf) begin
      display_control_pin_en = 1'b0;
    end else if (s_q.dlo_s2) begin
      display_control_pin_en = 1'b1;
    end else begin
      display_control_pin_en = evt_i.activity || evt_i.chg_detect;
    end
    learn_ok = s_q.flg.valid_dis && (s_q.temp_code >= CHGG_TEMP_ZERO_C);
    up_step  = evt_i.chg_cnt ? {8'h0, s_q.fast_chg ? CHGG_EFF_FAST : CHGG_EFF_TRICKLE}
                             : 16'h0;
    dn_step  = (evt_i.dis_cnt ? CHGG_DIS_STEP : 16'h0)
             + ((evt_i.sd_cnt && s_q.sd_en) ? CHGG_SELF_DIS_STEP : 16'h0);
  end

  // next state of the whole bank
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    s_d.dlo_s1 = display_control_pin_low_i;
    s_d.dlo_s2 = s_q.dlo_s1;
    s_d.dhi_s1 = display_control_pin_high_i;
    s_d.dhi_s2 = s_q.dhi_s1;
    s_d.pd_s1  = pulldown_i;
    s_d.pd_s2  = s_q.pd_s1;
    s_d.pu_s1  = pullup_i;
    s_d.pu_s2  = s_q.pu_s1;
    s_d.sd_en  = ~s_q.pu_s2[CHGG_FIFTH_PROGRAM_PIN_BIT];
    s_d.temp_code = (temp_code_i > CHGG_TEMP_MAX) ? CHGG_TEMP_MAX : temp_code_i;

    // charge counter
    s_d.avail_chg = chgg_sat(s_q.avail_chg, up_step, dn_step);
    if (evt_i.chg_detect) begin
      s_d.avail_chg[7:0] = 8'h0;
    end
    if (evt_i.valid_chg && s_q.flg.empty1) begin
      s_d.avail_chg = 16'h0;
    end

    // secondary flags
    if (evt_i.chg_detect && !s_q.fast_chg) begin
      s_d.fast_chg = 1'b1;
    end else if (evt_i.rate_low) begin
      s_d.fast_chg = 1'b0;
    end
    s_d.rate_bit = evt_i.below_150;
    if (evt_i.below_250) begin
      s_d.ovl = 1'b1;
    end else if (!evt_i.below_150) begin
      s_d.ovl = 1'b0;
    end

    // empty warnings: sampling held off during overload, cleared by valid charge
    if (evt_i.valid_chg) begin
      s_d.flg.empty1 = 1'b0;
      s_d.flg.emptyf = 1'b0;
    end else if (!s_q.ovl) begin
      s_d.flg.empty1 = s_q.flg.empty1 | evt_i.empty1_trip;
      s_d.flg.emptyf = s_q.flg.emptyf | evt_i.emptyf_trip;
    end

    // recharge-without-learn counter
    if (!near_full) begin
      s_d.rchg_hold = 1'b0;
    end
    if (evt_i.valid_chg && !(near_full && s_q.rchg_hold)) begin
      if (s_q.rchg_cnt != CHGG_RCHG_MAX) begin
        s_d.rchg_cnt = s_q.rchg_cnt + 8'h1;
      end
      if (s_q.rchg_cnt + 8'h1 == CHGG_RCHG_INACC) begin
        s_d.flg.cap_inacc = 1'b1;
      end
      s_d.rchg_hold = near_full;
    end

    // learning qualification and capacity update
    if (evt_i.dis_cnt && !s_q.flg.valid_dis && s_q.avail_chg[15:8] >= s_q.full_cap) begin
      s_d.flg.valid_dis = 1'b1;
      s_d.dis_meas      = 8'h0;
    end else if (evt_i.dis_cnt && s_q.flg.valid_dis && s_q.dis_meas != 8'hff) begin
      s_d.dis_meas = s_q.dis_meas + 8'h1;
    end
    if (evt_i.valid_chg || evt_i.sd_over) begin
      s_d.flg.valid_dis = 1'b0;
    end else if (s_d.flg.empty1 && !s_q.flg.empty1) begin
      s_d.flg.valid_dis = 1'b0;
      if (learn_ok) begin
        s_d.full_cap      = s_q.dis_meas;
        s_d.rchg_cnt      = 8'h0;
        s_d.flg.cap_inacc = 1'b0;
      end
    end

    // host writes; read-only offsets are ignored
    if (chgg_hit(req_i, CHGG_OFF_CHG_HIGH)) begin
      s_d.avail_chg[15:8] = req_i.wdata;
    end
    if (chgg_hit(req_i, CHGG_OFF_PACK_ID)) begin
      s_d.pack_id = req_i.wdata;
    end
    if (chgg_hit(req_i, CHGG_OFF_FULL_CAP)) begin
      s_d.full_cap = req_i.wdata;
    end
    if (chgg_hit(req_i, CHGG_OFF_FILTER)) begin
      s_d.filt = req_i.wdata;
    end
    s_d.soft_rst = chgg_hit(req_i, CHGG_OFF_SOFT_RESET)
                && (req_i.wdata == CHGG_SOFT_RESET_CODE);

    // read data, unused bits and unmapped offsets read zero
    if (req_i.rd) begin
      s_d.rvalid = 1'b1;
      case (req_i.addr)
        CHGG_OFF_TEMP_GAUGE: s_d.rdata = {s_q.temp_code, gauge};
        CHGG_OFF_CHG_HIGH:   s_d.rdata = s_q.avail_chg[15:8];
        CHGG_OFF_PACK_ID:    s_d.rdata = s_q.pack_id;
        CHGG_OFF_FULL_CAP:   s_d.rdata = s_q.full_cap;
        CHGG_OFF_SEC_FLAGS:  s_d.rdata = {s_q.fast_chg, 2'h0, s_q.rate_bit, 3'h0, s_q.ovl};
        CHGG_OFF_PULLDOWN:   s_d.rdata = {2'h0, s_q.pd_s2};
        CHGG_OFF_PULLUP:     s_d.rdata = {2'h0, s_q.pu_s2};
        CHGG_OFF_RCHG_COUNT: s_d.rdata = s_q.rchg_cnt;
        CHGG_OFF_FILTER:     s_d.rdata = s_q.filt;
        CHGG_OFF_CHG_LOW:    s_d.rdata = s_q.avail_chg[7:0];
        default:             s_d.rdata = 8'h0;
      endcase
    end
    if (s_q.soft_rst) begin
      s_d = s_rst;
    end
  end

  // state register, power-on reset also clears id, filter and pin sense
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q           <= '0;
      s_q.full_cap  <= CHGG_PROG_FULL_COUNT;
      s_q.filt      <= CHGG_FILTER_RESET;
      s_q.flg       <= '{cap_inacc: 1'b1, valid_dis: 1'b0, bat_repl: 1'b1,
                         empty1: 1'b0, emptyf: 1'b0};
      s_q.sd_en     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // segment multiplexing and blink
  chgg_led_mux #(
    .MUX_CYCLES   (MUX_CYCLES),
    .BLINK_CYCLES (BLINK_CYCLES)
  ) u_led (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .en_i     (display_control_pin_en),
    .blink_i  (s_q.flg.empty1),
    .seg_on_i (seg_on),
    .seg_o    (led_segment_outputs_o)
  );

  assign rdata_o     = s_q.rdata;
  assign rvalid_o    = s_q.rvalid;
  assign flags_o     = s_q.flg;
  assign filter_o    = s_q.filt;
  assign fast_chg_o  = s_q.fast_chg;
  assign sd_enable_o = s_q.sd_en;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_low_clear;
    evt_i.chg_detect && !s_q.soft_rst |=> s_q.avail_chg[7:0] == 8'h0;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low byte not cleared");

  property p_empty_clear;
    evt_i.valid_chg && s_q.flg.empty1 && !s_q.soft_rst && !req_i.wr
      |=> s_q.avail_chg == 16'h0 && !s_q.flg.empty1;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("counter kept after empty");

  property p_temp_range;
    s_q.temp_code <= CHGG_TEMP_MAX;
  endproperty
  a_temp_range: assert property (p_temp_range) else $error("temperature code out of range");

  property p_fast_set;
    evt_i.chg_detect && !s_q.fast_chg && !s_q.soft_rst |=> fast_chg_o;
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("fast flag not set");

  property p_rate_bit;
    req_i.rd && req_i.addr == CHGG_OFF_SEC_FLAGS && !s_q.soft_rst
      |=> rvalid_o && rdata_o[6:4] == {2'h0, $past(s_q.rate_bit)} && rdata_o[3:1] == 3'h0;
  endproperty
  a_rate_bit: assert property (p_rate_bit) else $error("rate field wrong");

  property p_ovl_hold;
    s_q.ovl && evt_i.empty1_trip && !s_q.flg.empty1 && !evt_i.valid_chg && !s_q.soft_rst
      |=> !s_q.flg.empty1;
  endproperty
  a_ovl_hold: assert property (p_ovl_hold) else $error("empty sampled in overload");

  property p_sat;
    s_q.rchg_cnt == CHGG_RCHG_MAX && !s_q.soft_rst |=> s_q.rchg_cnt != 8'h0 || $past(learn_ok);
  endproperty
  a_sat: assert property (p_sat) else $error("recharge counter wrapped");

  property p_inacc;
    s_q.rchg_cnt == 8'h3f ##1 s_q.rchg_cnt == CHGG_RCHG_INACC |-> s_q.flg.cap_inacc;
  endproperty
  a_inacc: assert property (p_inacc) else $error("inaccuracy flag missed at 64");

  property p_soft_reset;
    chgg_hit(req_i, CHGG_OFF_SOFT_RESET) && req_i.wdata == CHGG_SOFT_RESET_CODE
      |=> ##1 s_q.avail_chg == 16'h0 && s_q.rchg_cnt == 8'h0 && s_q.flg.cap_inacc
              && s_q.flg.bat_repl && s_q.full_cap == CHGG_PROG_FULL_COUNT;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_ro_write;
    chgg_hit(req_i, CHGG_OFF_RCHG_COUNT) && !evt_i.valid_chg && !s_q.soft_rst
      && !(s_d.flg.empty1 && !s_q.flg.empty1)
      |=> $stable(s_q.rchg_cnt);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only register written");

  c_learn: cover property (s_q.flg.valid_dis ##1 !s_q.flg.valid_dis && !s_q.flg.cap_inacc);
  c_soft:  cover property (s_q.soft_rst);
  c_blink: cover property (s_q.flg.empty1 && display_control_pin_en);

endmodule : chgg_regs

// [chgg_host_model.sv]
// chgg_host_model: host side of the register port, one request per call.
// assumes the bank answers a read on the taking edge, one cycle after the request is driven.
`timescale 1ns/1ps
module chgg_host_model (
  input  wire logic                clk_i,
  input  wire logic                rvalid_i,
  input  wire logic [7:0]          rdata_i,
  output chgg_pkg::chgg_req_t      req_o
);
  import chgg_pkg::*;
  initial req_o = '0;
  // one write strobe; the reset register only ever gets 80h
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i) req_o <= '0;
  endtask : wr
  // read strobe; data taken with the answer pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i) req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i) req_o <= '0;
    #1 v = rvalid_i;
    d = rdata_i;
  endtask : rd
endmodule : chgg_host_model

// [tb_top.sv]
// tb_top: self-checking bench of the charge gauge register bank.
// assumes a host model on the register port and short display counts.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t value %h", $time, (a)); end end
module tb_top;
  import chgg_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  chgg_req_t   req;
  chgg_evt_t   evt = '0;
  logic [7:0]  rdata;
  logic        rvalid, fast, sd_en;
  logic        display_control_pin_low = 1'b0;
  logic        display_control_pin_high = 1'b1;
  logic [3:0]  temp = 4'h7;
  logic [7:0]  filt;
  logic [4:0]  seg;
  chgg_flags_t flags;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #5 clk_i = ~clk_i;
  chgg_host_model chgg_host_model_inst (.clk_i(clk_i), .rvalid_i(rvalid),
    .rdata_i(rdata), .req_o(req));
  chgg_regs #(.MUX_CYCLES(20), .BLINK_CYCLES(50)) chgg_regs_inst (.clk_i(clk_i),
    .nrst_i(nrst_i), .req_i(req), .evt_i(evt), .temp_code_i(temp), .display_control_pin_low_i(display_control_pin_low),
    .display_control_pin_high_i(display_control_pin_high), .pulldown_i(6'b101001), .pullup_i(6'b010000), .rdata_o(rdata),
    .rvalid_o(rvalid), .flags_o(flags), .filter_o(filt), .fast_chg_o(fast),
    .sd_enable_o(sd_en), .led_segment_outputs_o(seg));
  // read one register and compare with the expected value
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    chgg_host_model_inst.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : rchk
  // one cycle event pulse from the front end
  task automatic ev(input chgg_evt_t e);
    @(posedge clk_i) evt <= e;
    @(posedge clk_i) evt <= '0;
    @(negedge clk_i);
  endtask : ev
  // let the pins settle, then gather every segment lit over one mux period
  task automatic seg_acc(output logic [4:0] acc);
    acc = 5'h00;
    repeat (4) @(posedge clk_i);
    repeat (20) @(negedge clk_i) acc = acc | seg;
  endtask : seg_acc
  // reset values, pins, read-only write, id, capacity and filter writes
  task automatic t_reset;
    rchk(CHGG_OFF_FULL_CAP, CHGG_PROG_FULL_COUNT);
    rchk(CHGG_OFF_CHG_HIGH, 8'h00);
    rchk(CHGG_OFF_RCHG_COUNT, 8'h00);
    `CHK(flags, 5'b10100)
    rchk(CHGG_OFF_PULLDOWN, 8'h29);
    rchk(CHGG_OFF_PULLUP, 8'h10);
    `CHK(sd_en, 1'b0)
    chgg_host_model_inst.wr(CHGG_OFF_RCHG_COUNT, 8'h55);
    rchk(CHGG_OFF_RCHG_COUNT, 8'h00);
    chgg_host_model_inst.wr(CHGG_OFF_PACK_ID, 8'h5a);
    rchk(CHGG_OFF_PACK_ID, 8'h5a);
    chgg_host_model_inst.wr(CHGG_OFF_FULL_CAP, 8'h80);
    rchk(CHGG_OFF_FULL_CAP, 8'h80);
    chgg_host_model_inst.wr(CHGG_OFF_FILTER, 8'h3c);
    rchk(CHGG_OFF_FILTER, 8'h3c);
    `CHK(filt, 8'h3c)
  endtask : t_reset
  // charge counting, low byte clear, fast flag, recharge count
  task automatic t_charge;
    ev('{chg_detect: 1'b1, default: 1'b0});
    `CHK(fast, 1'b1)
    repeat (2) ev('{chg_cnt: 1'b1, default: 1'b0});
    rchk(CHGG_OFF_CHG_HIGH, 8'h01);
    rchk(CHGG_OFF_CHG_LOW, 8'he0);
    ev('{chg_detect: 1'b1, default: 1'b0});
    rchk(CHGG_OFF_CHG_LOW, 8'h00);
    ev('{rate_low: 1'b1, default: 1'b0});
    rchk(CHGG_OFF_SEC_FLAGS, 8'h00);
    repeat (3) ev('{valid_chg: 1'b1, default: 1'b0});
    rchk(CHGG_OFF_RCHG_COUNT, 8'h03);
  endtask : t_charge
  // discharge rate and overload hold until above -150 mV
  task automatic t_rate;
    @(posedge clk_i) evt <= '{below_150: 1'b1, below_250: 1'b1, default: 1'b0};
    rchk(CHGG_OFF_SEC_FLAGS, 8'h11);
    @(posedge clk_i) evt <= '{below_150: 1'b1, default: 1'b0};
    rchk(CHGG_OFF_SEC_FLAGS, 8'h11);
    @(posedge clk_i) evt <= '0;
    rchk(CHGG_OFF_SEC_FLAGS, 8'h00);
    rchk(CHGG_OFF_TEMP_GAUGE, {4'h7, 4'h0});
  endtask : t_rate
  // gauge nibble, cold adjustment, segment banks, display pin and final warning
  task automatic t_display_control_pin;
    logic [4:0] acc;
    chgg_host_model_inst.wr(CHGG_OFF_CHG_HIGH, 8'h40);
    rchk(CHGG_OFF_TEMP_GAUGE, 8'h78);
    @(posedge clk_i) temp <= 4'h2;
    rchk(CHGG_OFF_TEMP_GAUGE, 8'h26);
    @(posedge clk_i) temp <= 4'hf;
    rchk(CHGG_OFF_TEMP_GAUGE, 8'hc8);
    @(posedge clk_i) display_control_pin_high <= 1'b0;
    display_control_pin_low <= 1'b1;
    seg_acc(acc);
    `CHK(acc, 5'h07)
    @(posedge clk_i) display_control_pin_high <= 1'b1;
    display_control_pin_low <= 1'b0;
    seg_acc(acc);
    `CHK(acc, 5'h00)
    @(posedge clk_i) display_control_pin_high <= 1'b0;
    display_control_pin_low <= 1'b1;
    evt <= '{emptyf_trip: 1'b1, default: 1'b0};
    seg_acc(acc);
    `CHK(acc, 5'h00)
    @(posedge clk_i) evt <= '0;
  endtask : t_display_control_pin
  // software reset through the reset register
  task automatic t_soft;
    chgg_host_model_inst.wr(CHGG_OFF_SOFT_RESET, CHGG_SOFT_RESET_CODE);
    repeat (2) @(posedge clk_i);
    rchk(CHGG_OFF_RCHG_COUNT, 8'h00);
    rchk(CHGG_OFF_FULL_CAP, CHGG_PROG_FULL_COUNT);
    rchk(CHGG_OFF_PACK_ID, 8'h5a);
    `CHK(flags, 5'b10100)
    `CHK(filt, 8'h3c)
  endtask : t_soft
  // counts and verdict, single exit of the run
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // cycle ceiling against hangs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_charge();
    t_rate();
    t_display_control_pin();
    t_soft();
    print_verdict();
  end
endmodule : tb_top
